/* rtl/cerc_top.v */
// Purpose: Cache error latching, notification and recovery controls
// Assumes: Error events are one-cycle pulses from the cache datapaths
// Notes: Status clears are write-one masks valid on their strobe
`timescale 1ns/1ps
`default_nettype none
`include "cerc_defines.vh"
module cerc_top (
	input wire clk,
	input wire resetn,
	input wire biuCtlWr,
	input wire biuCtlEnable,
	input wire pcCtlWr,
	input wire pcCtlEnable,
	input wire icsrWr,
	input wire icsrEnable,
	input wire forceHitWr,
	input wire forceHitIn,
	input wire diagInhibitWr,
	input wire diagInhibitIn,
	input wire bfsClrWr,
	input wire [`CERC_BFS_W-1:0] bfsClrMask,
	input wire pcsClrWr,
	input wire [`CERC_PCS_W-1:0] pcsClrMask,
	input wire tbsClr,
	input wire icsClr,
	input wire bcUncorrRead,
	input wire bcUncorrMchk,
	input wire bcCorrRead,
	input wire writeHardErr,
	input wire fillErr,
	input wire readLock,
	input wire firstQuad,
	input wire [`CERC_ADDR_W-1:0] errAddr,
	input wire pcTagErr,
	input wire pcDataErr,
	input wire pteReadErr,
	input wire tbParityErr,
	input wire icErr,
	input wire reiExec,
	input wire ldpctxExec,
	input wire bcRead,
	input wire [`CERC_SYN_W-1:0] readSyndrome,
	input wire lineWr,
	input wire [`CERC_IDX_W-1:0] lineIdx,
	input wire [`CERC_DATA_W-1:0] lineData,
	input wire fhRead,
	input wire [`CERC_IDX_W-1:0] fhIdx,
	output reg bcEnable_r,
	output reg pcEnable_r,
	output reg icEnable_r,
	output reg forceHit_r,
	output reg diagInhibit_r,
	output reg [`CERC_BFS_W-1:0] bfsStatus_r,
	output reg [`CERC_ADDR_W-1:0] errAddr_r,
	output reg [`CERC_PCS_W-1:0] pcsStatus_r,
	output reg tbsStatus_r,
	output reg icsStatus_r,
	output reg [`CERC_SYN_W-1:0] fillSyndrome_r,
	output reg mchk_r,
	output reg softErr_r,
	output reg hardErr_r,
	output reg icFlush_r,
	output reg tbInvAll_r,
	output reg tbInvProc_r,
	output reg fhValid_r,
	output reg [`CERC_DATA_W-1:0] fhData_r
);
	// Cleared bits drop, new events set; set wins over clear
	function [`CERC_BFS_W-1:0] w1cB;
		input [`CERC_BFS_W-1:0] cur;
		input [`CERC_BFS_W-1:0] clr;
		input [`CERC_BFS_W-1:0] set;
		begin
			w1cB = (cur & ~clr) | set;
		end
	endfunction
	function [`CERC_PCS_W-1:0] w1cP;
		input [`CERC_PCS_W-1:0] cur;
		input [`CERC_PCS_W-1:0] clr;
		input [`CERC_PCS_W-1:0] set;
		begin
			w1cP = (cur & ~clr) | set;
		end
	endfunction

	wire [`CERC_DATA_W-1:0] memData;
	reg fhPend_r;
	reg fhBad_r;

	cerc_line_mem uMem (
		.clk(clk),
		.wrEn(lineWr),
		.wrIdx(lineIdx),
		.wrData(lineData),
		.rdIdx(fhIdx),
		.rdData(memData)
	);

	wire rdlkFirst = fillErr & readLock & firstQuad;
	wire bcErr = bcUncorrRead | bcCorrRead | fillErr | writeHardErr;
	wire anyBusErr = bcErr;
	wire latched = |bfsStatus_r[`CERC_BFS_SEO-1:0];
	wire [`CERC_BFS_W-1:0] bfsClr = bfsClrWr ? bfsClrMask : {`CERC_BFS_W{1'b0}};
	wire [`CERC_PCS_W-1:0] pcsClr = pcsClrWr ? pcsClrMask : {`CERC_PCS_W{1'b0}};
	wire readErr = bcUncorrRead | fillErr;
	wire mchkEv = (bcUncorrRead & bcUncorrMchk) | rdlkFirst | tbParityErr | icErr
		| (readErr & bfsStatus_r[`CERC_BFS_HERR]);
	wire softEv = bcUncorrRead | bcCorrRead | pcTagErr | pcDataErr | icErr
		| (fillErr & ~(readLock & firstQuad));
	wire hardEv = writeHardErr;
	reg [`CERC_BFS_W-1:0] bfsSet;
	always @* begin
		bfsSet = {`CERC_BFS_W{1'b0}};
		bfsSet[`CERC_BFS_HERR] = writeHardErr;
		bfsSet[`CERC_BFS_SERR] = bcUncorrRead | bcCorrRead;
		bfsSet[`CERC_BFS_FILL_ECC] = fillErr & ~readLock;
		bfsSet[`CERC_BFS_FILL_RDLK] = fillErr & readLock;
		bfsSet[`CERC_BFS_SEO] = anyBusErr & latched;
		if (anyBusErr & latched) begin
			bfsSet[`CERC_BFS_SEO-1:0] = {`CERC_BFS_SEO{1'b0}};
		end
	end

	always @(posedge clk) begin
		if (!resetn) begin
			bcEnable_r <= 1'b0;
			pcEnable_r <= 1'b0;
			icEnable_r <= 1'b0;
			forceHit_r <= 1'b0;
			diagInhibit_r <= 1'b0;
			bfsStatus_r <= {`CERC_BFS_W{1'b0}};
			errAddr_r <= `CERC_ZERO32;
			pcsStatus_r <= {`CERC_PCS_W{1'b0}};
			tbsStatus_r <= 1'b0;
			icsStatus_r <= 1'b0;
			fillSyndrome_r <= `CERC_ZERO8;
			mchk_r <= 1'b0;
			softErr_r <= 1'b0;
			hardErr_r <= 1'b0;
			icFlush_r <= 1'b0;
			tbInvAll_r <= 1'b0;
			tbInvProc_r <= 1'b0;
			fhPend_r <= 1'b0;
			fhBad_r <= 1'b0;
			fhValid_r <= 1'b0;
			fhData_r <= `CERC_ZERO64;
		end else begin
			// Error auto-disable takes precedence over a same-cycle enable write
			if (bcErr) begin
				bcEnable_r <= 1'b0;
			end else if (biuCtlWr) begin
				bcEnable_r <= biuCtlEnable;
			end
			if (pcTagErr | pcDataErr | (biuCtlWr & ~biuCtlEnable)) begin
				pcEnable_r <= 1'b0;
			end else if (pcCtlWr) begin
				pcEnable_r <= pcCtlEnable;
			end
			if (icErr) begin
				icEnable_r <= 1'b0;
			end else if (icsrWr) begin
				icEnable_r <= icsrEnable;
			end
			if (forceHitWr) begin
				forceHit_r <= forceHitIn;
			end
			if (diagInhibitWr) begin
				diagInhibit_r <= diagInhibitIn;
			end
			bfsStatus_r <= w1cB(bfsStatus_r, bfsClr, bfsSet);
			if (anyBusErr & ~latched) begin
				errAddr_r <= errAddr;
			end
			pcsStatus_r <= w1cP(pcsStatus_r, pcsClr,
				{pteReadErr, pcDataErr, pcTagErr});
			tbsStatus_r <= (tbsStatus_r & ~tbsClr) | tbParityErr;
			icsStatus_r <= (icsStatus_r & ~icsClr) | icErr;
			if ((bcRead & diagInhibit_r) | (readErr & ~diagInhibit_r)) begin
				fillSyndrome_r <= readSyndrome;
			end
			// One notification per cycle, highest level first
			mchk_r <= mchkEv & ~hardEv;
			softErr_r <= softEv & ~mchkEv & ~hardEv;
			hardErr_r <= hardEv;
			icFlush_r <= reiExec;
			tbInvAll_r <= tbParityErr;
			tbInvProc_r <= ldpctxExec;
			fhPend_r <= fhRead & forceHit_r;
			fhBad_r <= bcUncorrRead;
			fhValid_r <= fhPend_r & ~fhBad_r & ~bcUncorrRead;
			fhData_r <= (fhPend_r & ~fhBad_r & ~bcUncorrRead) ? memData : `CERC_ZERO64;
		end
	end
endmodule
`default_nettype wire

/* rtl/cerc_defines.vh */
// Purpose: Constants for the cache error report and control block
// Assumes: One clock, synchronous active-low reset
// Notes: Included by bare name
// How it works
// - A cache that reports an error switches itself off until software re-enables it.
// - Clearing bus interface control bit 0 disables primary and backup caches.
// - Uncorrectable backup cache data error raises soft error, or machine check instead when enabled.
// - Hard error events raise neither machine check nor soft error.
// - A read error after a latched write hard error gives machine check with second error.
// - Machine check takes priority over soft error notification.
// - Read-lock fill error raises machine check on the first quadword, on later ones only after a latched write hard error.
// - Bus and fill error bits clear by writing one.
// - Primary cache tag, data and entry read errors clear by writing one.
// - Translation buffer errors clear by writing one.
// - Instruction cache errors clear by writing one.
// - A second bus or fill error sets the second error flag, keeps first address.
// - Return from exception flushes the instruction cache.
// - Translation buffer parity error starts an internal invalidate-all.
// - Load process context invalidates process-space translation entries.
// - Force-hit reads return the line at the read index, with no tag match, unless uncorrectable.
// - Syndrome loads on every read when error checking is inhibited.
`ifndef CERC_DEFINES_VH
`define CERC_DEFINES_VH
`define CERC_BIU_ENABLE_BIT 0
`define CERC_BFS_W 5
`define CERC_BFS_HERR 0
`define CERC_BFS_SERR 1
`define CERC_BFS_FILL_ECC 2
`define CERC_BFS_FILL_RDLK 3
`define CERC_BFS_SEO 4
`define CERC_PCS_W 3
`define CERC_PCS_TAG 0
`define CERC_PCS_DATA 1
`define CERC_PCS_PTE 2
`define CERC_ADDR_W 32
`define CERC_SYN_W 8
`define CERC_IDX_W 4
`define CERC_DATA_W 64
`define CERC_LINES 16
`define CERC_ZERO32 32'h00000000
`define CERC_ZERO8 8'h00
`define CERC_ZERO64 64'h0000000000000000
`endif

/* rtl/cerc_line_mem.v */
// Purpose: Backup cache line store for force-hit diagnostic reads
// Assumes: Synchronous write and registered read
// Notes: Data only, no tag kept; the read index alone selects the line
`timescale 1ns/1ps
`default_nettype none
`include "cerc_defines.vh"
module cerc_line_mem (
	input wire clk,
	input wire wrEn,
	input wire [`CERC_IDX_W-1:0] wrIdx,
	input wire [`CERC_DATA_W-1:0] wrData,
	input wire [`CERC_IDX_W-1:0] rdIdx,
	output reg [`CERC_DATA_W-1:0] rdData
);
	reg [`CERC_DATA_W-1:0] mem [0:`CERC_LINES-1];
	always @(posedge clk) begin
		if (wrEn) begin
			mem[wrIdx] <= wrData;
		end
		rdData <= mem[rdIdx];
	end
endmodule
`default_nettype wire

/* verif/cerc_top_chk.sv */
// Purpose: Port assertions for the cache error block
// Assumes: One clock, reset active low
// Notes: Bound into cerc_top
`timescale 1ns/1ps
`default_nettype none
module cerc_top_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic biuCtlWr,
	input wire logic biuCtlEnable,
	input wire logic pcCtlWr,
	input wire logic bcUncorrRead,
	input wire logic bcUncorrMchk,
	input wire logic writeHardErr,
	input wire logic fillErr,
	input wire logic readLock,
	input wire logic firstQuad,
	input wire logic tbParityErr,
	input wire logic icErr,
	input wire logic bfsClrWr,
	input wire logic bcEnable_r,
	input wire logic pcEnable_r,
	input wire logic [4:0] bfsStatus_r,
	input wire logic [31:0] errAddr_r,
	input wire logic mchk_r,
	input wire logic softErr_r,
	input wire logic hardErr_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	chk_lock_first:
	assert property (fillErr && readLock && firstQuad && !writeHardErr |=> mchk_r)
		else $error("first quad gave no mchk");
	chk_lock_later:
	assert property (fillErr && readLock && !firstQuad && !bcUncorrRead && !bfsStatus_r[0]
		&& !tbParityErr && !icErr |=> !mchk_r)
		else $error("later quad gave mchk");
	chk_biu_off:
	assert property (biuCtlWr && !biuCtlEnable && !pcCtlWr |=> !bcEnable_r && !pcEnable_r)
		else $error("caches still on");
	chk_auto_off:
	assert property (fillErr |=> !bcEnable_r)
		else $error("cache stayed on after error");
	chk_soft_err:
	assert property (bcUncorrRead && !bcUncorrMchk && !writeHardErr && !fillErr
		&& !bfsStatus_r[0] && !tbParityErr && !icErr |=> softErr_r && !mchk_r)
		else $error("no soft error");
	chk_hard_only:
	assert property (writeHardErr |=> hardErr_r && !mchk_r && !softErr_r)
		else $error("hard error not exclusive");
	chk_mchk_prio:
	assert property (bcUncorrRead && bcUncorrMchk && !writeHardErr |=> mchk_r && !softErr_r)
		else $error("mchk not above soft");
	chk_second_err:
	assert property ((|bfsStatus_r[3:0]) && fillErr && !bfsClrWr
		|=> bfsStatus_r[4] && $stable(errAddr_r))
		else $error("second error mishandled");
endmodule
bind cerc_top cerc_top_chk u_chk (.*);
`default_nettype wire

/* verif/tb_cerc_top.sv */
// Purpose: Directed bench for the cache error block
// Assumes: Events are one-cycle pulses launched on the rising edge
// Notes: Events, levels and data travel as three packed vectors
`timescale 1ns/1ps
`default_nettype none
`include "cerc_defines.vh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
	$display("mismatch %s exp %h got %h", n, e, a); end end
module tb_cerc_top;
	localparam int UNC = 22, HW = 20, FILL = 19, PT = 18, PD = 17, PTE = 16, TBP = 15;
	localparam int IC = 14, RETURN_FROM_EXCEPTION = 13, LDP = 12, RD = 11, FH = 10, BW = 9, PW = 8, IW = 7;
	localparam int FW = 6, DW = 5, BC = 4, PC = 3, TC = 2, ICC = 1, LW = 0;
	localparam int COR = 21;
	logic clk = 0;
	logic resetn = 0;
	logic [22:0] ev = '0;
	logic [15:0] lv = '0;
	logic [7:0] dv = '0;
	int fail_count = 0, tests_run = 0, cyc = 0;
	wire bcUncorrRead, bcCorrRead, writeHardErr, fillErr, pcTagErr, pcDataErr, pteReadErr;
	wire tbParityErr, icErr, reiExec, ldpctxExec, bcRead, fhRead, biuCtlWr, pcCtlWr, icsrWr;
	wire forceHitWr, diagInhibitWr, bfsClrWr, pcsClrWr, tbsClr, icsClr, lineWr, biuCtlEnable;
	wire pcCtlEnable, icsrEnable, forceHitIn, diagInhibitIn, bcUncorrMchk, readLock, firstQuad;
	wire bcEnable_r, pcEnable_r, icEnable_r, forceHit_r, diagInhibit_r, tbsStatus_r, icsStatus_r;
	wire mchk_r, softErr_r, hardErr_r, icFlush_r, tbInvAll_r, tbInvProc_r, fhValid_r;
	wire [4:0] bfsClrMask, bfsStatus_r;
	wire [2:0] pcsClrMask, pcsStatus_r;
	wire [31:0] errAddr, errAddr_r;
	wire [7:0] readSyndrome, fillSyndrome_r;
	wire [3:0] lineIdx, fhIdx;
	wire [63:0] lineData, fhData_r;
	assign {bcUncorrRead, bcCorrRead, writeHardErr, fillErr, pcTagErr, pcDataErr, pteReadErr,
		tbParityErr, icErr, reiExec, ldpctxExec, bcRead, fhRead, biuCtlWr, pcCtlWr, icsrWr,
		forceHitWr, diagInhibitWr, bfsClrWr, pcsClrWr, tbsClr, icsClr, lineWr} = ev;
	assign {biuCtlEnable, pcCtlEnable, icsrEnable, forceHitIn, diagInhibitIn, bcUncorrMchk,
		readLock, firstQuad, bfsClrMask, pcsClrMask} = lv;
	assign errAddr = {4{dv}};
	assign readSyndrome = dv;
	assign lineIdx = dv[3:0];
	assign fhIdx = dv[3:0];
	assign lineData = {8{dv}};
	cerc_top dut (.*);
	always #12.5 clk = ~clk;
	task end_sim;
		if (fail_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// One strobe cycle, results settled on return
	task fire(input logic [22:0] e, input logic [15:0] l, input logic [7:0] d);
		@(posedge clk);
		ev <= e;
		lv <= l;
		dv <= d;
		@(posedge clk);
		ev <= '0;
		#1;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			fail_count++;
			end_sim;
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		fire(1 << BW, 16'h8000, 0);
		fire(1 << PW, 16'h4000, 0);
		fire(1 << IW, 16'h2000, 0);
		`CHK("enables", 3'b111, {bcEnable_r, pcEnable_r, icEnable_r})
		fire(1 << FILL, 16'h0300, 8'h3C);
		`CHK("lock first", 3'b110, {mchk_r, bfsStatus_r[3], bcEnable_r})
		fire(1 << FILL, 16'h0200, 8'h77);
		`CHK("lock later", 2'b01, {mchk_r, bfsStatus_r[4]})
		`CHK("addr kept", 32'h3C3C3C3C, errAddr_r)
		fire(1 << BC, 16'h0000, 0);
		`CHK("zero mask", 2'b11, bfsStatus_r[4:3])
		fire(1 << BC, 16'h00F8, 0);
		`CHK("bfs clear", 5'h00, bfsStatus_r)
		fire(1 << HW, 0, 0);
		`CHK("hard", 4'b1001, {hardErr_r, mchk_r, softErr_r, bfsStatus_r[0]})
		fire(1 << FILL, 0, 8'h21);
		`CHK("read after hard", 2'b11, {mchk_r, bfsStatus_r[4]})
		fire(1 << BC, 16'h00F8, 0);
		fire(1 << UNC, 16'h0400, 0);
		`CHK("unc mchk", 2'b10, {mchk_r, softErr_r})
		fire(1 << BC, 16'h00F8, 0);
		fire(1 << UNC, 0, 0);
		`CHK("unc soft", 2'b01, {mchk_r, softErr_r})
		fire(1 << COR, 0, 0);
		`CHK("corr soft", 2'b01, {mchk_r, softErr_r})
		fire(1 << PT | 1 << PD | 1 << PTE, 0, 0);
		fire(1 << PC, 16'h0002, 0);
		`CHK("pcs clear", 3'h5, pcsStatus_r)
		fire(1 << TBP | 1 << IC, 0, 0);
		`CHK("tb ic err", 3'b111, {tbsStatus_r, icsStatus_r, tbInvAll_r})
		fire(1 << TC | 1 << ICC | 1 << RETURN_FROM_EXCEPTION | 1 << LDP, 0, 0);
		`CHK("clr flush", 4'h3, {tbsStatus_r, icsStatus_r, icFlush_r, tbInvProc_r})
		fire(1 << IW, 16'h2000, 0);
		`CHK("ic reenable", 1'b1, icEnable_r)
		fire(1 << BW, 16'h8000, 0);
		fire(1 << PW, 16'h4000, 0);
		fire(1 << BW, 0, 0);
		`CHK("biu off", 2'b00, {bcEnable_r, pcEnable_r})
		fire(1 << BW, 16'h8000, 0);
		fire(1 << PW, 16'h4000, 0);
		fire(1 << IW, 0, 0);
		fire(1 << PW, 0, 0);
		fire(1 << BW, 0, 0);
		`CHK("ordered off", 3'b000, {bcEnable_r, pcEnable_r, icEnable_r})
		fire(1 << DW, 16'h0800, 0);
		`CHK("inhibit on", 1'b1, diagInhibit_r)
		fire(1 << RD, 0, 8'h5A);
		`CHK("syn load", 8'h5A, fillSyndrome_r)
		fire(1 << DW, 0, 0);
		fire(1 << RD, 0, 8'h11);
		`CHK("syn held", 8'h5A, fillSyndrome_r)
		fire(1 << FH, 0, 8'hC5);
		@(posedge clk);
		#1;
		`CHK("no force hit", 1'b0, fhValid_r)
		fire(1 << FW | 1 << LW, 16'h1000, 8'hA5);
		`CHK("force mode", 1'b1, forceHit_r)
		fire(1 << FH, 0, 8'hC5);
		@(posedge clk);
		#1;
		`CHK("force hit", {1'b1, {8{8'hA5}}}, {fhValid_r, fhData_r})
		end_sim;
	end
endmodule
`default_nettype wire
